/* bench/pcg_checker.sv */
`timescale 1ns/10ps
module pcg_checker (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic crc_done_evt
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire ctl_rd = rd_go && s_axi_araddr == pcg_pkg::PCG_ADDR_CTRL;
    wire [4:0] cnt = s_axi_rdata[12:8];
    // depth follows the length field carried in the same read word
    wire big = s_axi_rdata[3:0] > pcg_pkg::PCG_BIG_LEN;
    wire [4:0] depth = big ? pcg_pkg::PCG_DEPTH_SMALL : pcg_pkg::PCG_DEPTH_BIG;
    ////////////////////////////////////////////////////////////////////////////
    property p_bv_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    a_bv_hold: assert property (p_bv_hold) else $error("write response dropped early");
    property p_rv_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rv_hold: assert property (p_rv_hold) else $error("read response dropped early");
    property p_ar_rv;
        s_axi_arready |-> s_axi_rvalid;
    endproperty
    a_ar_rv: assert property (p_ar_rv) else $error("read data late");
    property p_evt_pulse;
        crc_done_evt |=> !crc_done_evt;
    endproperty
    a_evt_pulse: assert property (p_evt_pulse) else $error("event longer than a cycle");
    property p_unmapped;
        rd_go && s_axi_araddr == pcg_pkg::PCG_ADDR_PWR
            |-> s_axi_rresp == pcg_pkg::PCG_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_poly_b0;
        rd_go && s_axi_araddr == pcg_pkg::PCG_ADDR_POLY |-> s_axi_rdata[0] == 1'h0;
    endproperty
    a_poly_b0: assert property (p_poly_b0) else $error("term bit zero set");
    property p_empty;
        ctl_rd |-> s_axi_rdata[6] == (cnt == 5'h00);
    endproperty
    a_empty: assert property (p_empty) else $error("empty flag wrong");
    property p_full;
        ctl_rd |-> s_axi_rdata[7] == (cnt == depth);
    endproperty
    a_full: assert property (p_full) else $error("full flag wrong");
    c_evt: cover property (crc_done_evt);
    c_full: cover property (ctl_rd && s_axi_rdata[7]);
    c_err: cover property (s_axi_bvalid && s_axi_bresp == pcg_pkg::PCG_RESP_SLVERR);
endmodule

bind pcg_top pcg_checker i_pcg_checker (.*);

/* bench/programmable_crc_generator_tb_top.sv */
`timescale 1ns/10ps
module programmable_crc_generator_tb_top;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic sleep_req = 1'h0;
    logic idle_req = 1'h0;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, lfsr = 32'h1A711727;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, crc_done_evt;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int n_errors = 0, check_count = 0, n_evt = 0, cyc = 0, evt_cyc = 0;
    pcg_top i_pcg_top (.*);
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (crc_done_evt === 1'h1) begin
            n_evt <= n_evt + 1;
            evt_cyc <= cyc;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er = pcg_pkg::PCG_RESP_OKAY);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        check(s_axi_bresp, er, "bresp");
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d,
            input logic [1:0] er = pcg_pkg::PCG_RESP_OKAY);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        s_axi_rready <= 1'h0;
        check(s_axi_rresp, er, "rresp");
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge core_clk);
        n_errors++;
        complete_run;
    end
    initial begin
        logic [31:0] d, c1, w, cv, poly;
        logic [15:0] msk, crc_m;
        logic [15:0] q[$];
        logic [3:0] len, sb;
        logic fb;
        int L, dep, cnt, e0, t0, t;
        // lengths only shrink, so stages above a shorter length never matter later
        logic [3:0] lens[5] = '{4'hF, 4'hB, 4'h8, 4'h7, 4'h4};
        crc_m = 16'h0000;
        repeat (6) @(posedge core_clk);
        rstn <= 1'h1;
        repeat (3) @(posedge core_clk);
        rd(pcg_pkg::PCG_ADDR_CTRL, d);
        check(d, 32'h40, "control reset");
        rd(pcg_pkg::PCG_ADDR_POLY, d);
        check(d, 32'h0, "poly reset");
        rd(pcg_pkg::PCG_ADDR_PWR, d, pcg_pkg::PCG_RESP_SLVERR);
        wr(pcg_pkg::PCG_ADDR_PWR, 32'hFFFF, 4'hF, pcg_pkg::PCG_RESP_SLVERR);
        for (int r = 0; r < 5; r++) begin
            len = lens[r];
            L = len + 1;
            dep = (len > 4'h7) ? 8 : 16;
            sb = (len > 4'h7) ? 4'h3 : 4'h1;
            msk = 16'hFFFF >> (15 - len);
            cv = {28'h0, len} | ((r == 4) ? 32'h2000 : 32'h0);
            lfsr = nxt(lfsr);
            poly = {16'h0, lfsr[15:0]};
            wr(pcg_pkg::PCG_ADDR_CTRL, cv, 4'h3);
            wr(pcg_pkg::PCG_ADDR_POLY, poly, 4'h3);
            rd(pcg_pkg::PCG_ADDR_POLY, d);
            check(d, poly & 32'hFFFE, "poly");
            e0 = n_evt;
            // fill to depth, overflow once, then refill
            for (int k = 0; k < 2 * dep + 1; k++) begin
                lfsr = nxt(lfsr);
                wr(pcg_pkg::PCG_ADDR_DATA, lfsr, sb);
                if (k == dep) q.delete();
                else q.push_back(lfsr[15:0] & msk);
                cnt = (k < dep) ? k + 1 : k - dep;
                rd(pcg_pkg::PCG_ADDR_CTRL, d);
                w = cv | (cnt << 8) | (32'(cnt == dep) << 7) | (32'(cnt == 0) << 6);
                check(d, w, "control count");
            end
            check(n_evt, e0, "overflow event");
            if (r == 1) idle_req <= 1'h1;
            t0 = cyc;
            wr(pcg_pkg::PCG_ADDR_CTRL, cv | 32'h10, 4'h3);
            if (r == 2) wr(pcg_pkg::PCG_ADDR_CTRL, cv, 4'h3);
            if (r > 2) begin
                sleep_req <= (r == 3);
                idle_req <= (r == 4);
                repeat (4) @(posedge core_clk);
                rd(pcg_pkg::PCG_ADDR_CTRL, c1);
                repeat (40) @(posedge core_clk);
                rd(pcg_pkg::PCG_ADDR_CTRL, d);
                check(d, c1, "frozen control");
                sleep_req <= 1'h0;
                idle_req <= 1'h0;
            end
            t = 0;
            d = 32'h0;
            while (d[6] !== 1'h1 && t < 300) begin
                rd(pcg_pkg::PCG_ADDR_CTRL, d);
                t++;
            end
            idle_req <= 1'h0;
            // event lands one cycle after empty, counter one more
            repeat (3) @(posedge core_clk);
            check(n_evt, e0 + 1, "done event");
            t = evt_cyc - t0;
            if (r < 3) check(32'(t >= L * dep && t <= (L + 1) * dep + 12), 1, "duration");
            while (q.size() > 0) begin
                w = q.pop_front();
                for (int i = L - 1; i >= 0; i--) begin
                    fb = w[i] ^ crc_m[L - 1];
                    crc_m = crc_m << 1;
                    if (fb) crc_m = crc_m ^ (poly[15:0] | 16'h0001);
                end
            end
            rd(pcg_pkg::PCG_ADDR_RES, d);
            check(d & msk, crc_m & msk, "crc result");
            rd(pcg_pkg::PCG_ADDR_DATA, d);
            check(d & msk, crc_m & msk, "crc data port");
        end
        complete_run;
    end
endmodule

/* hdl/pcg_top.sv */
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module pcg_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sleep_req,
    input wire logic idle_req,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic crc_done_evt
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync_q;
    logic rst_n;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) rst_sync_q <= 2'h0;
        else rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    logic [1:0] sleep_sync_q;
    logic [1:0] idle_sync_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_sync_q <= 2'h0;
            idle_sync_q <= 2'h0;
        end else begin
            sleep_sync_q <= {sleep_sync_q[0], sleep_req};
            idle_sync_q <= {idle_sync_q[0], idle_req};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    pcg_pkg::pcg_ctrl_t ctrl_q;
    logic [15:0] poly_q;
    logic [15:0] fifo_q [16];
    logic [3:0] wr_ptr_q;
    logic [3:0] rd_ptr_q;
    logic [4:0] fifo_word_count_q;
    logic [15:0] crc_q;
    logic [15:0] shreg_q;
    logic [3:0] bit_q;
    pcg_pkg::pcg_state_t state_q;
    logic evt_q;

    logic [4:0] len;
    logic [4:0] depth;
    logic fifo_full_flag;
    logic fifo_empty_flag;
    logic frozen;
    assign len = {1'b0, ctrl_q.poly_len_minus_one} + 5'h01;
    assign depth = (ctrl_q.poly_len_minus_one > pcg_pkg::PCG_BIG_LEN) ?
        pcg_pkg::PCG_DEPTH_SMALL : pcg_pkg::PCG_DEPTH_BIG;
    assign fifo_full_flag = (fifo_word_count_q == depth);
    assign fifo_empty_flag = (fifo_word_count_q == 5'h00);
    // idle halts only when software asked for it
    assign frozen = sleep_sync_q[1] | (idle_sync_q[1] & ctrl_q.idle_halt);

    ////////////////////////////////////////////////////////////////////////
    // write channel: address and data accepted in either order
    logic aw_hold_q;
    logic w_hold_q;
    logic [4:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic [4:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic wr_ok;
    assign wa = aw_hold_q ? aw_addr_q : s_axi_awaddr;
    assign wd = w_hold_q ? w_data_q : s_axi_wdata;
    assign ws = w_hold_q ? w_strb_q : s_axi_wstrb;
    assign wr_fire = (aw_hold_q | (s_axi_awvalid & s_axi_awready)) &
        (w_hold_q | (s_axi_wvalid & s_axi_wready)) & !frozen;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 5'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pcg_pkg::PCG_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_hold_q & !s_axi_awready & !s_axi_bvalid & !wr_fire;
            s_axi_wready <= !w_hold_q & !s_axi_wready & !s_axi_bvalid & !wr_fire;
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? pcg_pkg::PCG_RESP_OKAY : pcg_pkg::PCG_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid & s_axi_awready) begin
                    aw_hold_q <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    w_hold_q <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid & s_axi_bready) s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_ctrl;
    logic wr_poly;
    logic wr_data;
    logic wr_pwr;
    logic data_word_done;
    assign wr_ctrl = wr_fire & (wa == pcg_pkg::PCG_ADDR_CTRL);
    assign wr_poly = wr_fire & (wa == pcg_pkg::PCG_ADDR_POLY);
    assign wr_data = wr_fire & (wa == pcg_pkg::PCG_ADDR_DATA);
    assign wr_pwr = wr_fire & (wa == pcg_pkg::PCG_ADDR_PWR);
    assign wr_ok = (wa == pcg_pkg::PCG_ADDR_CTRL) | (wa == pcg_pkg::PCG_ADDR_POLY) |
        (wa == pcg_pkg::PCG_ADDR_DATA) | (wa == pcg_pkg::PCG_ADDR_RES);
    // word counts once its top byte lane is written
    assign data_word_done = wr_data & (ctrl_q.poly_len_minus_one > pcg_pkg::PCG_BIG_LEN ?
        ws[1] : ws[0]);

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
            poly_q <= 16'h0000;
        end else begin
            if (wr_ctrl & ws[1]) ctrl_q.idle_halt <= wd[pcg_pkg::PCG_IDLE_BIT];
            if (wr_ctrl & ws[0]) begin
                ctrl_q.shift_start <= wd[pcg_pkg::PCG_GO_BIT];
                ctrl_q.poly_len_minus_one <= wd[3:0];
            end
            if (wr_poly & ws[0]) poly_q[7:0] <= wd[7:0] & pcg_pkg::PCG_POLY_MASK[7:0];
            if (wr_poly & ws[1]) poly_q[15:8] <= wd[15:8];
        end
    end

    // unused upper bits are dropped by masking to the length
    logic [15:0] len_mask;
    assign len_mask = 16'hFFFF >> (5'h10 - len);

    always_ff @(posedge core_clk) begin
        if (data_word_done & !fifo_full_flag) fifo_q[wr_ptr_q] <= wd[15:0] & len_mask;
    end

    ////////////////////////////////////////////////////////////////////////
    logic take_word;
    logic last_bit;
    logic in_bit;
    logic fb;
    logic [15:0] crc_next;
    logic [15:0] top_sel;
    assign take_word = !frozen & (state_q == pcg_pkg::PCG_SH_LOAD);
    assign last_bit = (state_q == pcg_pkg::PCG_SH_RUN) & (bit_q == 4'h0) & !frozen;
    assign in_bit = shreg_q[bit_q];
    assign top_sel = crc_q >> ctrl_q.poly_len_minus_one;
    assign fb = in_bit ^ top_sel[0];
    assign crc_next = (({crc_q[14:0], 1'b0}) ^ ({16{fb}} & poly_q) ^ {15'h0, fb}) &
        len_mask;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= pcg_pkg::PCG_SH_IDLE;
            crc_q <= 16'h0000;
            shreg_q <= 16'h0000;
            bit_q <= 4'h0;
            rd_ptr_q <= 4'h0;
        end else if (!frozen) begin
            case (state_q)
                pcg_pkg::PCG_SH_IDLE: begin
                    // start cleared still drains: stop when count <= 1 at the last bit, leaving a word written in that cycle
                    if (ctrl_q.shift_start & !fifo_empty_flag) state_q <= pcg_pkg::PCG_SH_LOAD;
                end
                pcg_pkg::PCG_SH_LOAD: begin
                    shreg_q <= fifo_q[rd_ptr_q];
                    rd_ptr_q <= rd_ptr_q + 4'h1;
                    bit_q <= ctrl_q.poly_len_minus_one;
                    state_q <= pcg_pkg::PCG_SH_RUN;
                end
                pcg_pkg::PCG_SH_RUN: begin
                    crc_q <= crc_next;
                    bit_q <= bit_q - 4'h1;
                    if (bit_q == 4'h0) begin
                        state_q <= (fifo_word_count_q > 5'h01) ?
                            pcg_pkg::PCG_SH_LOAD : pcg_pkg::PCG_SH_IDLE;
                    end
                end
                default: state_q <= pcg_pkg::PCG_SH_IDLE;
            endcase
            if (fifo_full_flag & data_word_done) rd_ptr_q <= wr_ptr_q + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_word_count_q <= 5'h00;
            wr_ptr_q <= 4'h0;
            evt_q <= 1'b0;
            crc_done_evt <= 1'b0;
        end else begin
            evt_q <= 1'b0;
            if (data_word_done & fifo_full_flag) begin
                fifo_word_count_q <= 5'h00;
                wr_ptr_q <= wr_ptr_q + 4'h1;
            end else if (data_word_done & !last_bit) begin
                fifo_word_count_q <= fifo_word_count_q + 5'h01;
                wr_ptr_q <= wr_ptr_q + 4'h1;
            end else if (last_bit & !data_word_done) begin
                fifo_word_count_q <= fifo_word_count_q - 5'h01;
                evt_q <= (fifo_word_count_q == 5'h01);
            end else if (data_word_done) begin
                wr_ptr_q <= wr_ptr_q + 4'h1;
            end
            // events still leave while halted
            crc_done_evt <= evt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] rd_mux;
    logic rd_ok;
    logic [15:0] ctrl_view;
    logic [15:0] res_mask;
    assign ctrl_view = {2'h0, ctrl_q.idle_halt, fifo_word_count_q, fifo_full_flag,
        fifo_empty_flag, 1'b0, ctrl_q.shift_start, ctrl_q.poly_len_minus_one};
    assign res_mask = crc_q;
    assign rd_ok = (s_axi_araddr == pcg_pkg::PCG_ADDR_CTRL) |
        (s_axi_araddr == pcg_pkg::PCG_ADDR_POLY) |
        (s_axi_araddr == pcg_pkg::PCG_ADDR_DATA) | (s_axi_araddr == pcg_pkg::PCG_ADDR_RES);
    assign rd_mux = (s_axi_araddr == pcg_pkg::PCG_ADDR_CTRL) ? {16'h0, ctrl_view} :
        (s_axi_araddr == pcg_pkg::PCG_ADDR_POLY) ? {16'h0, poly_q} :
        ((s_axi_araddr == pcg_pkg::PCG_ADDR_DATA) |
         (s_axi_araddr == pcg_pkg::PCG_ADDR_RES)) ? {16'h0, res_mask} : 32'h0;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= pcg_pkg::PCG_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_rvalid) begin
                if (s_axi_rready) s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid & !s_axi_arready) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? pcg_pkg::PCG_RESP_OKAY : pcg_pkg::PCG_RESP_SLVERR;
            end
        end
    end
endmodule

/* include/pcg_pkg.sv */
package pcg_pkg;
    localparam logic [4:0] PCG_ADDR_CTRL = 5'h00;
    localparam logic [4:0] PCG_ADDR_POLY = 5'h04;
    localparam logic [4:0] PCG_ADDR_DATA = 5'h08;
    localparam logic [4:0] PCG_ADDR_RES = 5'h0C;
    localparam logic [4:0] PCG_ADDR_PWR = 5'h10;
    localparam int PCG_IDLE_BIT = 13;
    localparam int PCG_GO_BIT = 4;
    localparam int PCG_FULL_BIT = 7;
    localparam int PCG_EMPTY_BIT = 6;
    localparam int PCG_CNT_LSB = 8;
    localparam logic [3:0] PCG_BIG_LEN = 4'h7;
    localparam logic [4:0] PCG_DEPTH_SMALL = 5'h08;
    localparam logic [4:0] PCG_DEPTH_BIG = 5'h10;
    localparam logic [15:0] PCG_POLY_MASK = 16'hFFFE;
    localparam logic [1:0] PCG_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCG_RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic idle_halt;
        logic shift_start;
        logic [3:0] poly_len_minus_one;
    } pcg_ctrl_t;
    typedef enum logic [2:0] {
        PCG_SH_IDLE = 3'b001,
        PCG_SH_LOAD = 3'b010,
        PCG_SH_RUN = 3'b100
    } pcg_state_t;
endpackage
